// >>> logic/ocs_clock_ctrl.sv
// Oscillator start-up timers, main-clock slow clock prescaler and slow clock select.
// Assumes stop requests come from power management logic on clk_sys, and that
// the slow oscillator and reset pins are asynchronous.
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "ocs_params.svh"

module ocs_clock_ctrl #(
  parameter int MAIN_STARTUP_CYCLES = `OCS_MAIN_STARTUP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire ocs_pkg::ocs_pmm_req_t pmm_req,
  input wire logic slow_osc_input_pin,
  input wire logic ext_reset_n_pin,
  input wire logic [`OCS_ADDR_W-1:0] reg_addr,
  input wire logic [`OCS_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`OCS_DATA_W-1:0] reg_rdata_r,
  output logic fast_osc_output_pin,
  output logic slow_osc_output_pin,
  output logic slow_clk_r,
  output logic sys_rst_r,
  output ocs_pkg::ocs_status_t status
);
  import ocs_pkg::*;

  // Main timer steps once per this many system clock cycles
  localparam int MAIN_TICK_DIV = MAIN_STARTUP_CYCLES / `OCS_MAIN_TMR_STEPS;
  localparam logic [7:0] MAIN_TICK_LAST = 8'(MAIN_TICK_DIV - 1);
  localparam logic [`OCS_TOGGLE_CNT_W-1:0] TOGGLE_LAST = `OCS_TOGGLE_CNT_W'(`OCS_TOGGLE_TIMEOUT_CYC);

  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] sync3_r;
  logic slow_filt_r;
  logic ext_rst_n_filt_r;
  logic slow_filt_d_r;
  logic slow_rise;
  logic [7:0] main_tick_r;
  logic main_step;
  logic [`OCS_MAIN_TMR_W-1:0] main_cnt;
  logic [`OCS_SLOW_TMR_W-1:0] slow_cnt;
  logic main_good;
  logic slow_good;
  logic [`OCS_TOGGLE_CNT_W-1:0] idle_cnt_r;
  logic toggling_r;
  logic sel_osc_r;
  logic [`OCS_PRESC_W-1:0] presc_val_r;
  logic [`OCS_PRESC_W-1:0] presc_cnt_r;
  logic presc_clk_r;
  ocs_src_t src_r;
  ocs_src_t src_nxt;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Bit 0 slow oscillator, bit 1 reset pin; stage 1 feeds stage 2 only
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
      sync3_r <= 2'h0;
    end
    else if (ce)
    begin
      sync1_r <= {ext_reset_n_pin, slow_osc_input_pin};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      slow_filt_r <= 1'b0;
      ext_rst_n_filt_r <= 1'b0;
      slow_filt_d_r <= 1'b0;
    end
    else if (ce)
    begin
      if (sync2_r[0] == sync3_r[0])
      begin
        slow_filt_r <= sync3_r[0];
      end
      if (sync2_r[1] == sync3_r[1])
      begin
        ext_rst_n_filt_r <= sync3_r[1];
      end
      slow_filt_d_r <= slow_filt_r;
    end
  end

  assign slow_rise = slow_filt_r && !slow_filt_d_r;

  // ****************************************************************
  // Oscillator enables and start-up timers
  // ****************************************************************
  // Oscillators run whenever their stop request is low
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      fast_osc_output_pin <= 1'b0;
      slow_osc_output_pin <= 1'b0;
    end
    else if (ce)
    begin
      fast_osc_output_pin <= !pmm_req.stop_main;
      slow_osc_output_pin <= !pmm_req.stop_slow;
    end
  end

  // Scales timer steps so the full count spans the start-up cycle figure
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      main_tick_r <= 8'h00;
    end
    else if (ce)
    begin
      if (pmm_req.stop_main || main_step)
      begin
        main_tick_r <= 8'h00;
      end
      else
      begin
        main_tick_r <= main_tick_r + 8'h01;
      end
    end
  end

  assign main_step = (main_tick_r == MAIN_TICK_LAST);

  ocs_startup_timer #(
    .WIDTH(`OCS_MAIN_TMR_W)
  ) u_main_tmr (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .stop(pmm_req.stop_main),
    .step(main_step),
    .cnt_r(main_cnt),
    .good(main_good)
  );

  // Slow timer counts real oscillator edges, so a crystal that never starts never reports good
  ocs_startup_timer #(
    .WIDTH(`OCS_SLOW_TMR_W)
  ) u_slow_tmr (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .stop(pmm_req.stop_slow),
    .step(slow_rise),
    .cnt_r(slow_cnt),
    .good(slow_good)
  );

  // ****************************************************************
  // Internal reset
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sys_rst_r <= 1'b1;
    end
    else if (ce)
    begin
      sys_rst_r <= !(main_good && ext_rst_n_filt_r);
    end
  end

  // ****************************************************************
  // Toggle detector
  // ****************************************************************
  // Toggling while an edge was seen within the timeout window
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      idle_cnt_r <= '0;
      toggling_r <= 1'b0;
    end
    else if (ce)
    begin
      if (slow_rise)
      begin
        idle_cnt_r <= '0;
        toggling_r <= 1'b1;
      end
      else if (idle_cnt_r == TOGGLE_LAST)
      begin
        toggling_r <= 1'b0;
      end
      else
      begin
        idle_cnt_r <= idle_cnt_r + `OCS_TOGGLE_CNT_W'(1);
      end
    end
  end

  // ****************************************************************
  // Register port
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sel_osc_r <= `OCS_CTRL_RESET;
      presc_val_r <= `OCS_PRESC_RESET;
    end
    else if (ce && reg_wr)
    begin
      if (reg_addr == `OCS_REG_CTRL)
      begin
        sel_osc_r <= reg_wdata[`OCS_CTRL_SEL_OSC_BIT];
      end
      if (reg_addr == `OCS_REG_PRESC)
      begin
        presc_val_r <= reg_wdata[`OCS_PRESC_W-1:0];
      end
    end
  end

  assign status.main_good = main_good;
  assign status.slow_good = slow_good;
  assign status.toggling = toggling_r;
  assign status.src_osc = (src_r == OCS_SRC_OSC);

  // Unmapped addresses read as zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rdata_r <= '0;
    end
    else if (ce)
    begin
      reg_rdata_r <= '0;
      if (reg_rd)
      begin
        case (reg_addr)
          `OCS_REG_CTRL: reg_rdata_r[`OCS_CTRL_SEL_OSC_BIT] <= sel_osc_r;
          `OCS_REG_PRESC: reg_rdata_r[`OCS_PRESC_W-1:0] <= presc_val_r;
          `OCS_REG_STATUS: reg_rdata_r[3:0] <= status;
          default: reg_rdata_r <= '0;
        endcase
      end
    end
  end

  // ****************************************************************
  // Slow clock source select
  // ****************************************************************
  // Falls back to the prescaler as soon as the oscillator stops toggling
  always_comb
  begin
    src_nxt = src_r;
    case (src_r)
      OCS_SRC_PRESCALED:
      begin
        if (sel_osc_r && toggling_r && slow_good)
        begin
          src_nxt = OCS_SRC_OSC;
        end
      end
      OCS_SRC_OSC:
      begin
        if (!sel_osc_r || !toggling_r)
        begin
          src_nxt = OCS_SRC_PRESCALED;
        end
      end
      default: src_nxt = OCS_SRC_PRESCALED;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      src_r <= OCS_SRC_PRESCALED;
    end
    else if (ce)
    begin
      src_r <= src_nxt;
    end
  end

  // ****************************************************************
  // Main clock prescaler
  // ****************************************************************
  // Output toggles every N+1 cycles: divisor 2*(N+1), 2 to 512
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      presc_cnt_r <= '0;
      presc_clk_r <= 1'b0;
    end
    else if (ce)
    begin
      if (src_r == OCS_SRC_OSC)
      begin
        presc_cnt_r <= '0;
        presc_clk_r <= 1'b0;
      end
      else if (presc_cnt_r == '0)
      begin
        presc_cnt_r <= presc_val_r;
        presc_clk_r <= !presc_clk_r;
      end
      else
      begin
        presc_cnt_r <= presc_cnt_r - `OCS_PRESC_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      slow_clk_r <= 1'b0;
    end
    else if (ce)
    begin
      slow_clk_r <= (src_r == OCS_SRC_OSC) ? slow_filt_r : presc_clk_r;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_main_stop;
    ce && pmm_req.stop_main;
  endsequence

  sequence s_main_run_zero;
    ce && !pmm_req.stop_main && (main_cnt == '0);
  endsequence

  a_main_preset: assert property (s_main_stop |=> main_cnt == `OCS_MAIN_TMR_PRESET)
    else $error("main timer not preset under stop");
  a_main_hold_zero: assert property (s_main_run_zero |=> main_cnt == '0)
    else $error("main timer left zero without stop");
  a_main_count: assert property (ce && !pmm_req.stop_main && main_step && main_cnt != '0
    |=> main_cnt == $past(main_cnt) - 14'h0001)
    else $error("main timer did not decrement");
  // Only meaningful when several cycles make one step; a step per cycle is legal otherwise
  a_main_step_gap: assert property (MAIN_TICK_DIV > 1 && ce && !pmm_req.stop_main
    && main_step |=> !main_step)
    else $error("main timer stepped on consecutive cycles");
  a_main_good_rise: assert property ($rose(main_good) && $past(ce)
    |-> $past(main_cnt) == 14'h0001)
    else $error("main good rose before the timer counted down");
  a_slow_preset: assert property (ce && pmm_req.stop_slow |=> slow_cnt == `OCS_SLOW_TMR_PRESET)
    else $error("slow timer not preset under stop");
  a_slow_hold_zero: assert property (ce && !pmm_req.stop_slow && slow_cnt == '0
    |=> slow_cnt == '0)
    else $error("slow timer left zero without stop");
  a_good_stop_low: assert property (pmm_req.stop_main || main_cnt != '0 |-> !main_good)
    else $error("main good while stopped or counting");
  a_osc_needs_toggle: assert property ($rose(src_r == OCS_SRC_OSC)
    |-> $past(toggling_r) && $past(sel_osc_r))
    else $error("switched to slow oscillator without toggling");
  a_presc_off: assert property (ce && src_r == OCS_SRC_OSC
    |=> presc_cnt_r == '0 && !presc_clk_r)
    else $error("prescaler running while oscillator selected");
  a_sysrst_hold: assert property (ce && !main_good |=> sys_rst_r)
    else $error("internal reset released before main good");

endmodule : ocs_clock_ctrl

// >>> shared/ocs_params.svh
// Constants of the oscillator start-up and slow clock select block.
// Assumes a single 10 MHz system clock and a synchronous active-high reset.
`ifndef OCS_PARAMS_SVH
`define OCS_PARAMS_SVH

// ****************************************************************
// Clock figures
// ****************************************************************
`define OCS_CLK_PERIOD_NS 100
`define OCS_MAIN_CLK_NOM_HZ 12000000
`define OCS_SLOW_CLK_NOM_MHZ_X1000 32768
`define OCS_SLOW_MAX_KHZ 100

// ****************************************************************
// Start-up timers
// ****************************************************************
`define OCS_MAIN_TMR_W 14
`define OCS_SLOW_TMR_W 6
`define OCS_MAIN_TMR_PRESET 14'h3FFF
`define OCS_SLOW_TMR_PRESET 6'h3F
`define OCS_MAIN_STARTUP_CYCLES 32768
`define OCS_MAIN_TMR_STEPS 16384

// ****************************************************************
// Toggle detector
// ****************************************************************
`define OCS_TOGGLE_TIMEOUT_NS 100000
`define OCS_TOGGLE_TIMEOUT_CYC (`OCS_TOGGLE_TIMEOUT_NS / `OCS_CLK_PERIOD_NS)
`define OCS_TOGGLE_CNT_W 10

// ****************************************************************
// Register map and fields
// ****************************************************************
`define OCS_ADDR_W 4
`define OCS_DATA_W 32
`define OCS_REG_CTRL 4'h0
`define OCS_REG_PRESC 4'h1
`define OCS_REG_STATUS 4'h2
`define OCS_CTRL_SEL_OSC_BIT 0
`define OCS_CTRL_RESET 1'h0
`define OCS_PRESC_W 8
`define OCS_PRESC_RESET 8'h00
`define OCS_STAT_MAIN_GOOD_BIT 0
`define OCS_STAT_SLOW_GOOD_BIT 1
`define OCS_STAT_TOGGLING_BIT 2
`define OCS_STAT_SRC_OSC_BIT 3

`endif

// >>> shared/ocs_pkg.sv
// Types of the oscillator start-up and slow clock select block.
// Assumes ocs_params.svh is on the include path.
`include "ocs_params.svh"

package ocs_pkg;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic stop_main;
    logic stop_slow;
  } ocs_pmm_req_t;

  typedef struct packed {
    logic src_osc;
    logic toggling;
    logic slow_good;
    logic main_good;
  } ocs_status_t;

  // Gray coded along prescaled -> oscillator -> prescaled
  typedef enum logic [0:0] {
    OCS_SRC_PRESCALED = 1'b0,
    OCS_SRC_OSC = 1'b1
  } ocs_src_t;

endpackage : ocs_pkg

// >>> logic/ocs_startup_timer.sv
// Start-up countdown timer for one oscillator.
// Assumes stop comes from logic on clk_sys; step is a one-cycle count pulse.
`timescale 1ns/1ps

module ocs_startup_timer #(
  parameter int WIDTH = 6
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic stop,
  input wire logic step,
  output logic [WIDTH-1:0] cnt_r,
  output logic good
);
  import ocs_pkg::*;

  // Preset while stopped, count down after release, hold at zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_r <= '1;
    end
    else if (ce)
    begin
      if (stop)
      begin
        cnt_r <= '1;
      end
      else if (step && (cnt_r != '0))
      begin
        cnt_r <= cnt_r - WIDTH'(1);
      end
    end
  end

  assign good = (cnt_r == '0) && !stop;

endmodule : ocs_startup_timer

// >>> test/ocs_pmm_model.sv
// Power management stand-in that drives the two oscillator stop requests.
// Assumes bench commands on clk_sys; requests change only just after an edge.
`timescale 1ns/1ps

module ocs_pmm_model
  import ocs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic main_off,
  input wire logic slow_off,
  output ocs_pkg::ocs_pmm_req_t pmm_req
);
  // Both oscillators stay stopped in reset, so each start-up begins at its preset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pmm_req <= '{stop_main: 1'b1, stop_slow: 1'b1};
    else
      pmm_req <= '{stop_main: main_off, stop_slow: slow_off};
  end
endmodule : ocs_pmm_model

// >>> test/ocs_clock_ctrl_tb.sv
// Self-checking bench for the oscillator start-up and slow clock select block.
// Assumes ocs_pkg, ocs_params.svh and the power management model are compiled first.
`timescale 1ns/1ps
`include "ocs_params.svh"

module ocs_clock_ctrl_tb;
  import ocs_pkg::*;
  // One timer step per cycle keeps the main start-up to about 16k cycles
  localparam int STEPS = 16384;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic main_off = 1'b1;
  logic slow_off = 1'b1;
  logic slow_run = 1'b0;
  logic slow_pin = 1'b0;
  logic ext_rst_n = 1'b0;
  logic [`OCS_ADDR_W-1:0] reg_addr = '0;
  logic [`OCS_DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [`OCS_DATA_W-1:0] reg_rdata_r;
  logic fast_pin;
  logic slow_out_pin;
  logic slow_clk_r;
  logic sys_rst_r;
  ocs_pmm_req_t pmm_req;
  ocs_status_t status;
  int fail_count = 0;
  int checked = 0;

  always #50 clk_sys = ~clk_sys;

  // Crystal runs only while enabled; the odd half period keeps edges off clk_sys
  always #1537.3
  begin
    if (slow_run && slow_out_pin)
      slow_pin <= ~slow_pin;
  end

  ocs_pmm_model ocs_pmm_model_inst (.clk_sys(clk_sys), .rst(rst), .main_off(main_off),
    .slow_off(slow_off), .pmm_req(pmm_req));

  ocs_clock_ctrl #(.MAIN_STARTUP_CYCLES(STEPS)) ocs_clock_ctrl_inst (.clk_sys(clk_sys),
    .rst(rst), .ce(ce), .pmm_req(pmm_req), .slow_osc_input_pin(slow_pin),
    .ext_reset_n_pin(ext_rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .fast_osc_output_pin(fast_pin), .slow_osc_output_pin(slow_out_pin),
    .slow_clk_r(slow_clk_r), .sys_rst_r(sys_rst_r), .status(status));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int n, input int lo, input int hi);
    chk(32'(n), (n >= lo && n <= hi) ? 32'(n) : 32'(lo));
  endtask : chk_rng

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_r, exp);
  endtask : rd_chk

  // Cycles until the next rise of the slow clock; the third call gives a settled period
  task automatic rise_gap(output int n);
    logic prev;
    n = 0;
    do
    begin
      prev = slow_clk_r;
      cyc(1);
      n++;
    end
    while (!(prev === 1'b0 && slow_clk_r === 1'b1) && n < 2000);
  endtask : rise_gap

  task automatic period(output int n);
    repeat (3) rise_gap(n);
  endtask : period

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    chk(32'(sys_rst_r), 32'h1);
    chk(32'({fast_pin, slow_out_pin}), 32'h0);
    rd_chk(`OCS_REG_CTRL, 32'h0);
    rd_chk(`OCS_REG_PRESC, 32'h0);
    rd_chk(`OCS_REG_STATUS, 32'h0);
    reg_write(4'hF, 32'hFFFF_FFFF);
    rd_chk(4'hF, 32'h0);
  endtask : t_reset

  // PRESC is 0 here, so a running slow clock toggles every cycle
  task automatic t_freeze;
    logic v;
    @(posedge clk_sys);
    ce <= 1'b0;
    cyc(1);
    v = slow_clk_r;
    cyc(6);
    chk(32'(slow_clk_r), 32'(v));
    @(posedge clk_sys);
    ce <= 1'b1;
    cyc(3);
    chk(32'(slow_clk_r), 32'(!v));
  endtask : t_freeze

  task automatic t_main;
    int n;
    @(posedge clk_sys);
    ext_rst_n <= 1'b1;
    main_off <= 1'b0;
    cyc(2);
    chk(32'(fast_pin), 32'h1);
    n = 2;
    while (status.main_good !== 1'b1 && n < 20000)
    begin
      cyc(1);
      n++;
    end
    chk_rng(n, STEPS - 4, STEPS + 4);
    chk(32'(sys_rst_r), 32'h1);
    cyc(2);
    chk(32'(sys_rst_r), 32'h0);
    @(posedge clk_sys);
    ext_rst_n <= 1'b0;
    cyc(8);
    chk(32'(sys_rst_r), 32'h1);
    @(posedge clk_sys);
    ext_rst_n <= 1'b1;
    cyc(8);
    chk(32'({sys_rst_r, status.main_good}), 32'h1);
  endtask : t_main

  task automatic t_presc_one(input logic [7:0] v);
    int n;
    reg_write(`OCS_REG_PRESC, 32'(v));
    rd_chk(`OCS_REG_PRESC, 32'(v));
    period(n);
    chk(32'(n), 32'(2 * (v + 1)));
  endtask : t_presc_one

  task automatic t_select;
    int n;
    reg_write(`OCS_REG_CTRL, 32'h1);
    rd_chk(`OCS_REG_CTRL, 32'h1);
    cyc(20);
    chk(32'(status.src_osc), 32'h0);
    @(posedge clk_sys);
    slow_off <= 1'b0;
    slow_run <= 1'b1;
    cyc(2);
    chk(32'(slow_out_pin), 32'h1);
    n = 0;
    while (status.slow_good !== 1'b1 && n < 200)
    begin
      @(posedge slow_pin);
      #1;
      n++;
    end
    chk(32'(n), 32'h40);
    cyc(10);
    rd_chk(`OCS_REG_STATUS, 32'hF);
    period(n);
    chk_rng(n, 30, 31);
    reg_write(`OCS_REG_CTRL, 32'h0);
    cyc(2);
    chk(32'(status.src_osc), 32'h0);
    reg_write(`OCS_REG_CTRL, 32'h1);
    cyc(2);
    chk(32'(status.src_osc), 32'h1);
    @(posedge clk_sys);
    slow_run <= 1'b0;
    cyc(1100);
    chk(32'({status.src_osc, status.toggling}), 32'h0);
    period(n);
    chk(32'(n), 32'h64);
  endtask : t_select

  task automatic t_stop;
    @(posedge clk_sys);
    main_off <= 1'b1;
    slow_off <= 1'b1;
    cyc(2);
    chk(32'({fast_pin, slow_out_pin}), 32'h0);
    chk(32'({status.main_good, status.slow_good}), 32'h0);
    cyc(2);
    chk(32'(sys_rst_r), 32'h1);
  endtask : t_stop

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(1);
    t_reset();
    t_freeze();
    t_main();
    t_presc_one(8'hFF);
    t_presc_one(8'h31);
    t_select();
    t_stop();
    finish_test();
  end

  // Tests need about 22k cycles; more than twice that means a hang
  initial
  begin
    #(60000 * `OCS_CLK_PERIOD_NS);
    fail_count++;
    finish_test();
  end
endmodule : ocs_clock_ctrl_tb
